//--- dv/spi_host_model.sv
// host side model: drives frames of header and data bytes at the port
`timescale 1ns/1ps
module spi_host_model (
  input  wire logic ref_clk_i, // bench clock
  input  wire logic rd_i,      // read data as the host sees it
  output logic      sclk_o,    // serial clock, idle low
  output logic      cs_n_o,    // chip select
  output logic      mosi_o     // data towards the device
);
  int low_len = 6; // low half of sclk lasts this plus one ref cycles; raise it to stall

  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end

  // data changes with the falling clock; read bit taken just before the rise
  task automatic bit_slot(input logic b, output logic r);
    @(posedge ref_clk_i);
    sclk_o <= 1'b0;
    mosi_o <= b;
    repeat (low_len) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    r = rd_i;
    @(posedge ref_clk_i);
    sclk_o <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
  endtask

  task automatic frame(input logic rw, input logic [14:0] addr,
                       input int nb, input logic lsb,
                       input logic [31:0] wd, output logic [31:0] rd);
    logic [15:0] hdr;
    logic        r;
    int          j;
    hdr = {rw, addr};
    rd = '0;
    @(posedge ref_clk_i);
    cs_n_o <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      bit_slot(lsb ? hdr[i] : hdr[15-i], r);
    end
    for (int i = 0; i < 8 * nb; i++) begin
      j = lsb ? i : 8 * (i / 8) + 7 - i % 8;
      bit_slot(wd[j], r);
      rd[j] = r;
    end
    @(posedge ref_clk_i);
    sclk_o <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
    cs_n_o <= 1'b1;
    mosi_o <= ~mosi_o; // no stale level once the frame is over
    repeat (4) @(posedge ref_clk_i);
  endtask
endmodule // spi_host_model

//--- dv/tb_top.sv
// bench for the serial control port: frames, buffers, converter, outputs
`timescale 1ns/1ps
module tb_top;
  import synth_ctrl_pkg::*;
  logic           ref_clk_i, reset_i, sclk, cs_n, mosi, sdio_w, rd_line;
  logic           sdio_o, sdio_oe_n_o, sdo_o, lsb, four, up, single;
  logic           rb_main, src, cal_done, p1, p2, pd1, pd2, a1, a2, s1, s2;
  logic           busy, cal_busy, cal_start;
  logic [7:0]     div, sample;
  logic [8:0]     temp;
  logic [31:0]    rd;
  buffer_enable_t ben;
  synth_cfg_t     cfg;
  int             mismatches = 0, checks = 0, run = 0, last_run = 0;
  int             starts = 0;

  assign sdio_w  = sdio_oe_n_o ? mosi : sdio_o; // shared pin level
  assign rd_line = four ? sdo_o : sdio_w;

  spi_host_model u_spi_host_model (
    .ref_clk_i(ref_clk_i), .rd_i(rd_line), .sclk_o(sclk), .cs_n_o(cs_n),
    .mosi_o(mosi));

  serial_control_port #(.ADC_DIV_W(8)) u_serial_control_port (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .sclk_i(sclk),
    .cs_n_i(cs_n), .sdio_i(sdio_w), .sdio_o(sdio_o),
    .sdio_oe_n_o(sdio_oe_n_o), .sdo_o(sdo_o), .lsb_first_i(lsb),
    .four_wire_select_i(four), .stream_address_up_i(up),
    .single_transfer_i(single), .buffer_enable_i(ben),
    .readback_main_i(rb_main), .adc_clk_source_i(src),
    .adc_clk_div_i(div), .adc_sample_i(sample), .cal_done_i(cal_done),
    .output1_enable_pin_i(p1), .output2_enable_pin_i(p2),
    .output1_power_down_i(pd1), .output2_power_down_i(pd2),
    .synth_cfg_o(cfg), .adc_busy_o(busy), .calibration_busy_o(cal_busy),
    .cal_start_o(cal_start), .chip_temp_o(temp), .output1_active_o(a1),
    .output2_active_o(a2), .output1_pin_state_o(s1),
    .output2_pin_state_o(s2));

  initial begin
    ref_clk_i = 1'b0;
    forever #20 ref_clk_i = ~ref_clk_i;
  end

  // busy run length and calibration starts, sampled before each edge lands
  always @(posedge ref_clk_i) begin
    if (busy === 1'b1) begin
      run++;
    end else if (run != 0) begin
      last_run = run;
      run = 0;
    end
    if (cal_start === 1'b1) begin
      starts++;
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %0h want %0h", $time, seen, exp);
    end
  endtask

  task automatic complete_run;
    if (mismatches == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [14:0] a, input int n, input logic [31:0] d);
    u_spi_host_model.frame(1'b0, a, n, lsb, d, rd);
  endtask

  task automatic rdr(input logic [14:0] a, input int n);
    u_spi_host_model.frame(1'b1, a, n, lsb, 32'hFFFF_FFFF, rd);
  endtask

  task automatic wait_idle;
    for (int i = 0; i < 2000 && busy !== 1'b0; i++) @(negedge ref_clk_i);
    repeat (2) @(negedge ref_clk_i);
  endtask

  task automatic cal_finish;
    @(posedge ref_clk_i);
    cal_done <= 1'b1;
    @(posedge ref_clk_i);
    cal_done <= 1'b0;
    @(negedge ref_clk_i);
    check(32'(cal_busy), 32'h0);
    @(posedge ref_clk_i);
  endtask

  task automatic t_commit;
    int exp;
    exp = ADC_CONV_TICKS * ADC_DIV_MIN;
    wr(15'h0011, 1, 32'h07);
    check(32'(cfg.feedback_int), 32'h0);
    rb_main <= 1'b1;
    rdr(15'h0011, 1);
    check(rd, 32'h07);
    rb_main <= 1'b0;
    rdr(15'h0011, 1);
    check(rd, 32'h0);
    wr(15'h0013, 4, 32'h3407_4B0A);
    check(32'(cfg.feedback_int), 32'h734);
    check(32'(cfg.reference_divider), 32'h0B);
    check(32'(cfg.reference_doubler_enable), 32'h1);
    check(32'(cfg.charge_pump_current), 32'hA);
    check(32'(busy), 32'h1);
    wait_idle;
    check(32'(last_run > exp - ADC_DIV_MIN && last_run <= exp + 1),
          1);
    check(32'(temp), 32'hC5);
    check(32'(cal_busy), 32'h1);
    check(32'(starts), 32'h1);
    cal_finish;
  endtask

  task automatic t_convert;
    sample <= 8'h3C;
    wr(ADDR_ADC_START, 1, 32'h0);
    rdr(ADDR_ADC_STATUS, 1);
    check(rd, 32'h1);
    wait_idle;
    rdr(ADDR_ADC_STATUS, 1);
    check(rd, 32'h0);
    up <= 1'b1;
    rdr(ADDR_TEMP_LO, 2);
    check(rd, 32'h3C);
    check(32'(starts), 32'h1);
  endtask

  task automatic t_modes;
    u_spi_host_model.low_len = 12;
    ben <= '0;
    for (int m = 0; m < 4; m++) begin
      {four, lsb} <= 2'(m);
      @(posedge ref_clk_i);
      wr(15'h0019, 1, 32'h50 + m);
      check(32'(cfg.feedback_delay), 32'h50 + m);
      rdr(15'h0019, 1);
      check(rd, 32'h50 + m);
    end
    u_spi_host_model.low_len = 6;
  endtask

  task automatic t_single;
    single <= 1'b1;
    up <= 1'b0;
    wr(15'h001A, 2, 32'h0122);
    check(32'(cfg.reference_delay), 32'h22);
    check(32'(cfg.feedback_delay), 32'h53);
    single <= 1'b0;
    // unbuffered stream down 0x18..0x15 reaches the calclk, manual_osc, bleed and invert fields
    wr(15'h0018, 4, 32'h0355_A50E);
    check(32'(cfg.bleed_current), 32'h2A5);
    check(32'(cfg.bleed_polarity), 32'h1);
    check(32'(cfg.output_invert), 32'h1);
    check(32'(cfg.manual_osc), 32'h55);
    check(32'({cfg.calclk_div1, cfg.calclk_div2}), 32'h3);
  endtask

  task automatic t_group;
    ben.outdiv_buffer_enable <= 1'b1;
    src <= 1'b1;
    wr(15'h0014, 1, 32'h2);
    check(32'(cfg.output_divider), 32'h0);
    wr(ADDR_COMMIT, 1, 32'h34);
    check(32'(cfg.output_divider), 32'h2);
    check(32'(busy), 32'h0);
    check(32'(starts), 32'h2);
    check(32'(cal_busy), 32'h1);
    cal_finish;
    ben.outdiv_buffer_enable <= 1'b0;
    wr(15'h0014, 1, 32'h1);
    check(32'(cfg.output_divider), 32'h1);
    // serial-clocked conversion, as the host uses in full power-down
    sample <= 8'h5A;
    wr(ADDR_ADC_START, 1, 32'h0);
    check(32'(busy), 32'h1);
    rdr(ADDR_TEMP_LO, 1);
    check(32'(busy), 32'h0);
    check(32'(temp), 32'h5A);
    check(32'(starts), 32'h2);
  endtask

  task automatic t_outputs;
    for (int v = 0; v < 16; v++) begin
      @(posedge ref_clk_i);
      {p1, p2, pd1, pd2} <= 4'(v);
      repeat (3) @(posedge ref_clk_i);
      @(negedge ref_clk_i);
      check(32'({a1, a2, s1, s2}),
            32'({v[3] & ~v[1], v[2] & ~v[0], v[3:2]}));
    end
  endtask

  initial begin
    {reset_i, lsb, four, up, single, rb_main, src, cal_done} = 8'h80;
    {p1, p2, pd1, pd2} = 4'hC;
    ben = '0;
    div = 8'(ADC_DIV_MIN - 1);
    sample = 8'hC5;
    repeat (3) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    @(negedge ref_clk_i);
    check(32'(cfg === '0 && sdio_oe_n_o === 1'b1 && busy === 1'b0), 1);
    t_commit;
    t_convert;
    t_modes;
    t_single;
    t_group;
    t_outputs;
    complete_run;
  end

  // roughly four times the expected length of the whole sequence
  initial begin
    repeat (40000) @(posedge ref_clk_i);
    mismatches++;
    complete_run;
  end
endmodule // tb_top

//--- inc/synth_ctrl_pkg.sv
// shared constants and types for the serial control port
package synth_ctrl_pkg;

  localparam int HDR_BITS  = 16;
  localparam int DATA_BITS = 8;

  localparam logic [14:0] ADDR_COMMIT     = 15'h0010;
  localparam logic [14:0] ADDR_ADC_START  = 15'h0045;
  localparam logic [14:0] ADDR_ADC_STATUS = 15'h0049;
  localparam logic [14:0] ADDR_TEMP_LO    = 15'h004C;
  localparam logic [14:0] ADDR_TEMP_HI    = 15'h004D;

  // buffered bytes sit at ADDR_COMMIT + index
  localparam int BUF_COUNT = 11;
  localparam logic [7:0] BUF_RESET  = 8'h00;
  localparam logic [8:0] TEMP_RESET = 9'h000;

  // group index per buffered byte: 0 always buffered, 1..4 switchable
  localparam logic [2:0] BUF_GROUP [BUF_COUNT] =
    '{3'h0, 3'h0, 3'h0, 3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h4, 3'h4, 3'h4};

  localparam int ADC_CONV_TICKS = 17;
  localparam int REF_CLK_HZ     = 25_000_000;
  localparam int ADC_MAX_HZ     = 400_000;
  localparam int ADC_DIV_MIN    = (REF_CLK_HZ + ADC_MAX_HZ - 1) / ADC_MAX_HZ;

  typedef struct packed {
    logic delay_buffer_enable;
    logic manual_osc_buffer_enable;
    logic calclk_div_buffer_enable;
    logic outdiv_buffer_enable;
  } buffer_enable_t;

  typedef struct packed {
    logic [11:0] feedback_int;
    logic [5:0]  reference_divider;
    logic        reference_doubler_enable;
    logic [3:0]  charge_pump_current;
    logic [1:0]  output_divider;
    logic        calclk_div1;
    logic        calclk_div2;
    logic [7:0]  manual_osc;
    logic [9:0]  bleed_current;
    logic        bleed_polarity;
    logic        output_invert;
    logic [6:0]  feedback_delay;
    logic [6:0]  reference_delay;
  } synth_cfg_t;

endpackage

//--- logic/serial_control_port.sv
// serial control port, double-buffered settings and temperature ADC control
// Operation
// [R1] each transaction opens with a 16-bit instruction header
// [R2] header low fifteen bits are address, top bit is direction
// [R3] direction 1 reads, 0 writes; data phases are eight bits each
// [R4] bit-order bit picks MSB first (0) or LSB first (1) everywhere
// [R5] three-wire reads drive the data pin, four-wire reads drive sdo
// [R6] streaming continues with further registers without new headers
// [R7] address-direction bit steps streaming address up or down
// [R8] single-transfer bit set means one register per header
// [R9] buffered fields: writes reach main copy; subordinate drives hardware
// [R10] write to 0x10 copies all enabled main copies to subordinates
// [R11] write to 0x10 also starts oscillator calibration
// [R12] buffering disabled: writes go straight to the subordinate copy
// [R13] readback-select bit returns main or subordinate copy
// [R14] feedback, reference divider, doubler, pump current always buffered
// [R15] four groups have their own buffering enable bits
// [R16] conversion starts on 0x45 write, or 0x10 write on ref clock
// [R17] conversion started by 0x10 hands over to calibration when done
// [R18] a conversion takes exactly 17 ADC clock cycles
// [R19] busy flag at 0x49 reads 1 during a conversion
// [R20] 9-bit result stored across 0x4C and 0x4D
// [R21] converter is 8-bit and gives relative temperature only
// [R22] host keeps ADC clock at or below 400 kHz
// [R23] source bit picks divided reference (0) or serial clock (1)
// [R24] host uses serial clock for full power-down measurements
// [R25] outputs off on low pin or power-down; pin levels reported
// [R26] conversion busy falls before calibration busy falls
`timescale 1ns/1ps
module serial_control_port
  import synth_ctrl_pkg::*;
#(
  parameter int ADC_DIV_W = 8  // width of the ADC clock divider setting
)(
  input  wire logic                 ref_clk_i,            // 25 MHz clock
  input  wire logic                 reset_i,              // sync, active high
  input  wire logic                 sclk_i,               // serial clock
  input  wire logic                 cs_n_i,               // chip select
  input  wire logic                 sdio_i,               // data pin in
  output logic                      sdio_o,               // data pin out
  output logic                      sdio_oe_n_o,          // data pin enable
  output logic                      sdo_o,                // four-wire out
  input  wire logic                 lsb_first_i,          // bit order
  input  wire logic                 four_wire_select_i,   // read pin select
  input  wire logic                 stream_address_up_i,  // stream step
  input  wire logic                 single_transfer_i,    // no streaming
  input  wire buffer_enable_t       buffer_enable_i,      // group buffering
  input  wire logic                 readback_main_i,      // read main copy
  input  wire logic                 adc_clk_source_i,     // 1: serial clock
  input  wire logic [ADC_DIV_W-1:0] adc_clk_div_i,        // ref divider
  input  wire logic [7:0]           adc_sample_i,         // converter code
  input  wire logic                 cal_done_i,           // calibration end
  input  wire logic                 output1_enable_pin_i, // enable pin 1
  input  wire logic                 output2_enable_pin_i, // enable pin 2
  input  wire logic                 output1_power_down_i, // power-down 1
  input  wire logic                 output2_power_down_i, // power-down 2
  output synth_cfg_t                synth_cfg_o,          // operating copy
  output logic                      adc_busy_o,           // conversion runs
  output logic                      calibration_busy_o,   // calibration runs
  output logic                      cal_start_o,          // start pulse
  output logic [8:0]                chip_temp_o,          // last result
  output logic                      output1_active_o,     // output 1 on
  output logic                      output2_active_o,     // output 2 on
  output logic                      output1_pin_state_o,  // pin 1 level
  output logic                      output2_pin_state_o   // pin 2 level
);

  if (ADC_DIV_W < 6 || ADC_DIV_W > 16) begin : g_chk
    $error("ADC_DIV_W must be 6..16");
  end

  logic        sclk_q;
  logic [15:0] hdr;
  logic [4:0]  hcnt;
  logic        data_phase;
  logic        rw;
  logic        xfer_end;
  logic [14:0] addr;
  logic [7:0]  rx;
  logic [2:0]  dcnt;
  logic [7:0]  main_q [BUF_COUNT];
  logic [7:0]  sub_q  [BUF_COUNT];
  logic [ADC_DIV_W-1:0] div_cnt;
  logic        div_tick;
  logic [4:0]  conv_cnt;
  logic        from_commit;

  wire rise   = sclk_i & ~sclk_q;
  wire fall   = ~sclk_i & sclk_q;
  wire active = ~cs_n_i;

  wire [15:0] next_hdr = lsb_first_i ? {sdio_i, hdr[15:1]}
                                     : {hdr[14:0], sdio_i}; // see [R4]
  wire [7:0]  next_rx  = lsb_first_i ? {sdio_i, rx[7:1]}
                                     : {rx[6:0], sdio_i}; // see [R4]
  wire hdr_done  = active & rise & ~data_phase
                 & (hcnt == 5'(HDR_BITS - 1)); // see [R1]
  wire byte_done = active & rise & data_phase & ~xfer_end
                 & (dcnt == 3'(DATA_BITS - 1)); // see [R3]
  wire wr_fire   = byte_done & ~rw; // see [R3]
  wire [14:0] next_addr = stream_address_up_i ? addr + 15'h0001
                                              : addr - 15'h0001; // see [R7]

  wire        in_buf  = (addr >= ADDR_COMMIT)
                      && (addr < ADDR_COMMIT + 15'(BUF_COUNT));
  wire [3:0]  buf_idx = 4'(addr - ADDR_COMMIT);
  wire        commit  = wr_fire & (addr == ADDR_COMMIT); // see [R10]
  wire [4:0]  grp_on  = {buffer_enable_i, 1'b1}; // see [R14] [R15]

  wire [7:0] buf_rd = readback_main_i ? main_q[buf_idx]
                                      : sub_q[buf_idx]; // see [R13]
  wire [7:0] rdata =
    in_buf ? buf_rd :
    (addr == ADDR_ADC_STATUS) ? {6'h00, calibration_busy_o, adc_busy_o} :
    (addr == ADDR_TEMP_LO) ? chip_temp_o[7:0] :
    (addr == ADDR_TEMP_HI) ? {7'h00, chip_temp_o[8]} : 8'h00; // see [R19]
  wire       rd_phase = active & data_phase & rw & ~xfer_end;
  wire [2:0] bit_sel  = lsb_first_i ? dcnt
                                    : 3'(DATA_BITS - 1) - dcnt; // see [R4]

  // serial inputs are taken as synchronous, so one sample gives the edges
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) sclk_q <= 1'b0;
    else         sclk_q <= sclk_i;
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      hdr        <= 16'h0000;
      hcnt       <= 5'h00;
      data_phase <= 1'b0;
      rw         <= 1'b0;
      xfer_end   <= 1'b0;
      addr       <= 15'h0000;
      rx         <= 8'h00;
      dcnt       <= 3'h0;
    end else if (cs_n_i) begin
      hcnt       <= 5'h00;
      data_phase <= 1'b0;
      xfer_end   <= 1'b0;
      dcnt       <= 3'h0;
    end else if (rise && !data_phase) begin
      hdr  <= next_hdr;
      hcnt <= hcnt + 5'h01;
      if (hdr_done) begin
        data_phase <= 1'b1;
        rw         <= next_hdr[15]; // see [R2]
        addr       <= next_hdr[14:0]; // see [R2]
      end
    end else if (rise && !xfer_end) begin
      rx   <= next_rx;
      dcnt <= dcnt + 3'h1;
      if (byte_done) begin
        addr     <= next_addr; // see [R6]
        xfer_end <= single_transfer_i; // see [R8]
      end
    end
  end

  // read bits change on the falling edge so the host samples them rising
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      sdo_o       <= 1'b0;
      sdio_o      <= 1'b0;
      sdio_oe_n_o <= 1'b1;
    end else if (cs_n_i) begin
      sdio_oe_n_o <= 1'b1;
    end else if (fall) begin
      if (rd_phase) begin
        sdo_o       <= four_wire_select_i & rdata[bit_sel]; // see [R5]
        sdio_o      <= rdata[bit_sel];
        sdio_oe_n_o <= four_wire_select_i; // see [R5]
      end else begin
        sdio_oe_n_o <= 1'b1;
      end
    end
  end

  for (genvar i = 0; i < BUF_COUNT; i++) begin : g_buf
    wire en  = grp_on[BUF_GROUP[i]];
    wire hit = wr_fire & in_buf & (buf_idx == 4'(i));
    always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
        main_q[i] <= BUF_RESET;
        sub_q[i]  <= BUF_RESET;
      end else begin
        if (hit && en) main_q[i] <= next_rx; // see [R9]
        if (commit && en) sub_q[i] <= hit ? next_rx : main_q[i]; // see [R10]
        else if (hit && !en) sub_q[i] <= next_rx; // see [R12]
      end
    end
  end

  // only subordinate copies reach the synthesizer
  assign synth_cfg_o = {sub_q[1][3:0], sub_q[0], sub_q[2][5:0], sub_q[2][6],
                        sub_q[3][3:0], sub_q[4][1:0], sub_q[5][0],
                        sub_q[5][1], sub_q[6], sub_q[8][1:0], sub_q[7],
                        sub_q[8][2], sub_q[8][3], sub_q[9][6:0],
                        sub_q[10][6:0]}; // see [R9] [R14] [R15]

  // reference-derived ADC clock; the setting must keep it under 400 kHz
  always_ff @(posedge ref_clk_i) begin
    if (reset_i || div_cnt >= adc_clk_div_i) begin
      div_cnt  <= '0;
      div_tick <= ~reset_i;
    end else begin
      div_cnt  <= div_cnt + 1'b1;
      div_tick <= 1'b0;
    end
  end

  wire adc_tick  = adc_clk_source_i ? rise : div_tick; // see [R23]
  wire adc_start = wr_fire & ((addr == ADDR_ADC_START)
                 | (commit & ~adc_clk_source_i)); // see [R16]
  wire conv_done = adc_busy_o & adc_tick & ~adc_start
                 & (conv_cnt == 5'(ADC_CONV_TICKS - 1)); // see [R18]
  // on the serial clock no conversion precedes, so calibration starts at once
  wire cal_go = (conv_done & from_commit)
              | (commit & adc_clk_source_i); // see [R11] [R17]

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      adc_busy_o  <= 1'b0;
      conv_cnt    <= 5'h00;
      from_commit <= 1'b0;
      chip_temp_o <= TEMP_RESET;
    end else if (adc_start) begin
      adc_busy_o  <= 1'b1; // see [R19]
      conv_cnt    <= 5'h00;
      from_commit <= commit;
    end else if (adc_busy_o && adc_tick) begin
      conv_cnt <= conv_cnt + 5'h01;
      if (conv_done) begin
        adc_busy_o  <= 1'b0; // see [R19]
        chip_temp_o <= {1'b0, adc_sample_i}; // see [R20] [R21]
      end
    end
  end

  // a new start wins over a done in the same cycle
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      calibration_busy_o <= 1'b0;
      cal_start_o        <= 1'b0;
    end else begin
      cal_start_o <= cal_go;
      if (cal_go) calibration_busy_o <= 1'b1; // see [R26]
      else if (cal_done_i) calibration_busy_o <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      output1_active_o    <= 1'b0;
      output2_active_o    <= 1'b0;
      output1_pin_state_o <= 1'b0;
      output2_pin_state_o <= 1'b0;
    end else begin
      output1_active_o    <= output1_enable_pin_i & ~output1_power_down_i;
      output2_active_o    <= output2_enable_pin_i & ~output2_power_down_i;
      output1_pin_state_o <= output1_enable_pin_i; // see [R25]
      output2_pin_state_o <= output2_enable_pin_i; // see [R25]
    end
  end

  logic [4:0] tick_seen;
  always_ff @(posedge ref_clk_i) begin
    if (reset_i || adc_start) tick_seen <= 5'h00;
    else if (adc_busy_o && adc_tick) tick_seen <= tick_seen + 5'h01;
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);

  sequence conv_end_s;
    conv_done && from_commit;
  endsequence
  sequence cal_begin_s;
    cal_start_o && calibration_busy_o && !adc_busy_o;
  endsequence

  AST_HDR_LEN: assert property ($rose(data_phase) |-> $past(hcnt) == 5'd15) // see [R1]
    else $error("header not 16 bits");
  AST_HDR_FIELDS: assert property (hdr_done |=>
    addr == $past(next_hdr[14:0]) && rw == $past(next_hdr[15])) // see [R2]
    else $error("header fields wrong");
  AST_LSB_OUT: assert property (fall && rd_phase && lsb_first_i
    && dcnt == 3'd0 |=> sdio_o == $past(rdata[0])) // see [R4]
    else $error("lsb-first bit wrong");
  AST_PIN_SEL: assert property (fall && rd_phase && !four_wire_select_i
    |=> !sdio_oe_n_o && !sdo_o) // see [R5]
    else $error("three-wire read pin wrong");
  AST_STREAM_STEP: assert property (byte_done |=> addr == ($past(
    stream_address_up_i) ? $past(addr) + 15'd1 : $past(addr) - 15'd1)) // see [R7]
    else $error("stream step wrong");
  AST_SINGLE: assert property (byte_done && single_transfer_i
    |=> xfer_end ##1 (xfer_end || cs_n_i)) // see [R8]
    else $error("single transfer continued");
  AST_SUB_HOLD: assert property (!commit |=> sub_q[0] == $past(sub_q[0])) // see [R9]
    else $error("subordinate changed without commit");
  AST_COMMIT: assert property (commit |=> sub_q[1] == $past(main_q[1])) // see [R10]
    else $error("commit did not load");
  AST_DIRECT: assert property (wr_fire && in_buf && buf_idx == 4'd4
    && !buffer_enable_i.outdiv_buffer_enable
    |=> sub_q[4] == $past(next_rx)) // see [R12]
    else $error("direct write missed");
  AST_ADC_START: assert property (adc_start |=> adc_busy_o) // see [R16]
    else $error("conversion did not start");
  AST_CONV_LEN: assert property ($fell(adc_busy_o) |-> tick_seen == 5'd17) // see [R18]
    else $error("conversion not 17 ticks");
  AST_CAL_AFTER: assert property (conv_end_s |=> cal_begin_s) // see [R17]
    else $error("calibration did not follow");
  AST_OUT_OFF: assert property (output1_power_down_i |=> !output1_active_o) // see [R25]
    else $error("output not disabled");

endmodule // serial_control_port
